// ===== hw/pmpc_pin_cell.sv
/*
  Per-pin pad control resolution: effective direction, drive, pull.
  Assumes direction overrides are computed by the caller; pure logic.
*/
module pmpc_pin_cell
  import pmpc_pkg::*;
(
  input  wire logic      dir_eff,
  input  wire logic      dout,
  input  wire logic      reduced_bit,
  input  wire logic      pullen_bit,
  input  wire logic      pol_bit,
  input  wire logic      od_bit,
  input  wire logic      block_pulldown,
  output pmpc_pad_t      pad
);
  // Open-drain drives only a low level
  wire   od_float   = dir_eff & od_bit & dout;
  wire   drv_on     = dir_eff & ~od_float;
  // Pull is meaningful on inputs and wired-or outputs only
  wire   pull_ok    = ~dir_eff | od_bit;
  wire   pull_req   = pullen_bit & pull_ok;
  // A blocked pull-down is dropped rather than flipped to pull-up
  wire   pull_kill  = pol_bit & block_pulldown;

  assign pad.oe        = drv_on;
  assign pad.dout      = od_bit ? 1'b0 : dout;
  assign pad.reduced   = reduced_bit & dir_eff;
  assign pad.pull_on   = pull_req & ~pull_kill;
  assign pad.pull_down = pol_bit & ~pull_kill;
endmodule

// ===== hw/pmpc_pkg.sv
/*
  Package for the port pin configuration block: register offsets, reset
  values, pin roles and the per-pin pad control carrier.
  Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
// Summary of operation
// - Direction bit 1 makes the pin an output, 0 an input, per pin.
// - Enabled SPI forces direction of pins 5..2; stored bits stay unchanged.
// - Enabled CAN forces pin 1 to output; stored direction bit unchanged.
// - Enabled CAN forces pin 0 to input; stored direction bit unchanged.
// - Drive bit 1 selects reduced drive (about one fifth), 0 full drive.
// - Drive selection has no effect on a pin acting as input.
// - Drive selection applies to outputs whatever function drives them.
// - Pull enable bit 1 activates the pull device on an input pin.
// - On outputs the pull enable works only in wired-or mode.
// - Polarity bit 1 selects pull-down, 0 pull-up, when pull enabled.
// - While CAN is active, pull-down on the CAN receive pin has no effect.
// - Wired-or output drives low for zero and leaves pin undriven for one.
package pmpc_pkg;
  localparam int          PMPC_NPINS       = 6;
  localparam int          PMPC_REGW        = 8;
  localparam int          PMPC_AW          = 5;
  // Register byte addresses
  localparam logic [4:0]  PMPC_OFS_DIR     = 5'h00;
  localparam logic [4:0]  PMPC_OFS_DRIVE   = 5'h04;
  localparam logic [4:0]  PMPC_OFS_PULLEN  = 5'h08;
  localparam logic [4:0]  PMPC_OFS_POL     = 5'h0C;
  localparam logic [4:0]  PMPC_OFS_ODSEL   = 5'h10;
  localparam logic [4:0]  PMPC_OFS_STATUS  = 5'h14;
  localparam logic [5:0]  PMPC_RST_BITS    = 6'h00;
  // Pin roles
  localparam int          PMPC_CAN_TX_PIN  = 1;
  localparam int          PMPC_CAN_RX_PIN  = 0;
  localparam int          PMPC_SPI_LO_PIN  = 2;
  localparam int          PMPC_SPI_HI_PIN  = 5;

  // Pad control for one pin
  typedef struct packed {
    logic oe;        // Output driver enabled
    logic dout;      // Value driven when oe
    logic reduced;   // Reduced drive strength
    logic pull_on;   // Pull device active
    logic pull_down; // 1 pull-down, 0 pull-up
  } pmpc_pad_t;

  // Peripheral requests for a pin
  typedef struct packed {
    logic dir_out;   // Peripheral wants output
    logic dout;      // Peripheral output value
  } pmpc_periph_t;
endpackage

// ===== hw/pmpc_port_cfg.sv
/*
  Port pin configuration block: Wishbone registers for direction, drive,
  pull enable, pull polarity and open-drain select, plus SPI/CAN overrides.
  Assumes SPI and CAN enables and requests come from logic on clk.
*/
module pmpc_port_cfg
  import pmpc_pkg::*;
#(
  parameter int NPINS = PMPC_NPINS
)(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [PMPC_AW-1:0]   wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  input  wire logic [3:0]           wb_sel_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 spi_enable,
  input  wire pmpc_periph_t [3:0]   spi_req,
  input  wire logic                 can_enable,
  input  wire logic                 can_transmit_pin,
  input  wire logic [NPINS-1:0]     gpio_dout,
  output pmpc_pad_t [NPINS-1:0]     pad_ctl
);
  logic [NPINS-1:0] pin_direction_bits_ff;
  logic [NPINS-1:0] drive_strength_bits_ff;
  logic [NPINS-1:0] pull_enable_bits_ff;
  logic [NPINS-1:0] pull_polarity_bits_ff;
  logic [NPINS-1:0] open_drain_select_bits_ff;
  logic             ack_ff;
  logic [31:0]      rdata_ff;
  pmpc_pad_t [NPINS-1:0] pad_ff;
  pmpc_pad_t [NPINS-1:0] nxt_pad;
  logic [NPINS-1:0] dir_eff;
  logic [NPINS-1:0] dout_eff;

  // Bus decode; single-cycle answer after the request edge
  wire        req      = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire        wr_lane0 = req & wb_we_i & wb_sel_i[0];
  wire        hit_dir  = wb_adr_i == PMPC_OFS_DIR;
  wire        hit_drv  = wb_adr_i == PMPC_OFS_DRIVE;
  wire        hit_pen  = wb_adr_i == PMPC_OFS_PULLEN;
  wire        hit_pol  = wb_adr_i == PMPC_OFS_POL;
  wire        hit_od   = wb_adr_i == PMPC_OFS_ODSEL;
  wire        hit_st   = wb_adr_i == PMPC_OFS_STATUS;
  wire [NPINS-1:0] wdat = wb_dat_i[NPINS-1:0];

  // Read mux; unmapped addresses and upper bits read zero
  wire [NPINS-1:0] rsel =
      hit_dir ? pin_direction_bits_ff :
      hit_drv ? drive_strength_bits_ff :
      hit_pen ? pull_enable_bits_ff :
      hit_pol ? pull_polarity_bits_ff :
      hit_od  ? open_drain_select_bits_ff :
      hit_st  ? dir_eff : '0;
  wire [31:0] nxt_rdata = {{(32-NPINS){1'b0}}, rsel};

  // Register writes; stored direction never touched by overrides
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_direction_bits_ff     <= PMPC_RST_BITS;
      drive_strength_bits_ff    <= PMPC_RST_BITS;
      pull_enable_bits_ff       <= PMPC_RST_BITS;
      pull_polarity_bits_ff     <= PMPC_RST_BITS;
      open_drain_select_bits_ff <= PMPC_RST_BITS;
    end else begin
      if (wr_lane0 && hit_dir) pin_direction_bits_ff     <= wdat;
      if (wr_lane0 && hit_drv) drive_strength_bits_ff    <= wdat;
      if (wr_lane0 && hit_pen) pull_enable_bits_ff       <= wdat;
      if (wr_lane0 && hit_pol) pull_polarity_bits_ff     <= wdat;
      if (wr_lane0 && hit_od)  open_drain_select_bits_ff <= wdat;
    end
  end

  // Bus answer; ack drops the cycle after it rises
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff   <= req;
      rdata_ff <= req ? nxt_rdata : 32'h0000_0000;
    end
  end

  // Direction and data resolution per pin, peripherals take precedence
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      if (gi >= PMPC_SPI_LO_PIN && gi <= PMPC_SPI_HI_PIN) begin : g_spi
        assign dir_eff[gi]  = spi_enable ? spi_req[gi-PMPC_SPI_LO_PIN].dir_out
                                         : pin_direction_bits_ff[gi];
        assign dout_eff[gi] = spi_enable ? spi_req[gi-PMPC_SPI_LO_PIN].dout
                                         : gpio_dout[gi];
      end else if (gi == PMPC_CAN_TX_PIN) begin : g_tx
        assign dir_eff[gi]  = can_enable | pin_direction_bits_ff[gi];
        assign dout_eff[gi] = can_enable ? can_transmit_pin : gpio_dout[gi];
      end else if (gi == PMPC_CAN_RX_PIN) begin : g_rx
        assign dir_eff[gi]  = ~can_enable & pin_direction_bits_ff[gi];
        assign dout_eff[gi] = gpio_dout[gi];
      end else begin : g_plain
        assign dir_eff[gi]  = pin_direction_bits_ff[gi];
        assign dout_eff[gi] = gpio_dout[gi];
      end
      pmpc_pin_cell u_cell (
        .dir_eff        (dir_eff[gi]),
        .dout           (dout_eff[gi]),
        .reduced_bit    (drive_strength_bits_ff[gi]),
        .pullen_bit     (pull_enable_bits_ff[gi]),
        .pol_bit        (pull_polarity_bits_ff[gi]),
        .od_bit         (open_drain_select_bits_ff[gi]),
        .block_pulldown (can_enable && gi == PMPC_CAN_RX_PIN),
        .pad            (nxt_pad[gi])
      );
    end
  endgenerate

  // Pad controls registered so outputs come from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pad_ff <= '0;
    else     pad_ff <= nxt_pad;
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign pad_ctl  = pad_ff;
endmodule

// ===== verif/pmpc_periph_model.sv
/* SPI and CAN controllers that share the port pins.
   Assumes go is a one-cycle request from the bench. */
module pmpc_periph_model
  import pmpc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          go,
  output pmpc_periph_t [3:0] spi_req,
  output logic               spi_enable,
  output logic               can_enable,
  output logic               can_transmit_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // New ownership per request, held between so pads settle
  always @(posedge clk) begin
    if (rst) begin
      {spi_enable, spi_req, can_enable, can_transmit_pin} <= '0;
    end else if (go) begin
      {spi_enable, spi_req, can_enable, can_transmit_pin} <= 11'($urandom);
    end
  end
endmodule

// ===== verif/pmpc_port_cfg_assertions.sv
/* Checker on the pin configuration block's ports.
   Assumes cyc and stb rise and fall together. */
module pmpc_port_cfg_assertions
  import pmpc_pkg::*;
#(
  parameter int NPINS = PMPC_NPINS
)(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic                  spi_enable,
  input wire pmpc_periph_t [3:0]    spi_req,
  input wire logic                  can_enable,
  input wire logic                  can_transmit_pin,
  input wire pmpc_pad_t [NPINS-1:0] pad_ctl
);
  timeunit 1ns;
  timeprecision 1ps;
  // One domain; pads lag their causes by one edge
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_ACK_TAKEN:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_RD_UPPER:
    assert property (wb_ack_o |-> wb_dat_o[31:6] == '0) else $error("upper bits set");
  AST_CAN_TX:
    assert property (can_enable && !can_transmit_pin |=> pad_ctl[1].oe && !pad_ctl[1].dout) else $error("tx");
  AST_CAN_RX:
    assert property (can_enable |=> !pad_ctl[0].oe && !pad_ctl[0].reduced) else $error("rx driven");
  AST_CAN_RX_PULL:
    assert property (can_enable |=> !pad_ctl[0].pull_down) else $error("rx pull-down");
  AST_SPI_OUT:
    assert property (spi_enable && spi_req[0].dir_out && !spi_req[0].dout |=> pad_ctl[2].oe) else $error("spi out");
  AST_SPI_IN:
    assert property (spi_enable && !spi_req[3].dir_out |=> !pad_ctl[5].oe && !pad_ctl[5].reduced) else $error("spi in");
  // Main traffic kinds
  cover property (wb_ack_o && wb_dat_o != '0);
  cover property (can_enable && spi_enable);
  cover property (spi_enable ##1 !spi_enable);
endmodule
bind pmpc_port_cfg pmpc_port_cfg_assertions #(.NPINS(NPINS)) u_chk (.clk, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .spi_enable, .spi_req, .can_enable, .can_transmit_pin, .pad_ctl);

// ===== verif/tb.sv
/* Bench: random registers, data and peripheral states vs a model.
   Assumes the peripheral model and the bound checker. */
module tb
  import pmpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk, rst, cyc, we, go, ack, spi_en, can_en, can_tx;
  logic [4:0]         adr;
  logic [3:0]         sel;
  logic [5:0]         gpio, sx, e;
  logic [31:0]        dat, rd, q;
  pmpc_periph_t [3:0] sreq;
  pmpc_pad_t [5:0]    pad;
  int                 r[6], err_total, checks, a, n, k, d, o, od, pe;
  pmpc_port_cfg pmpc_port_cfg_i (.clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rd), .wb_ack_o(ack), .spi_enable(spi_en), .spi_req(sreq),
    .can_enable(can_en), .can_transmit_pin(can_tx), .gpio_dout(gpio), .pad_ctl(pad));
  pmpc_periph_model pmpc_periph_model_i (.clk, .rst, .go, .spi_req(sreq), .spi_enable(spi_en),
    .can_enable(can_en), .can_transmit_pin(can_tx));
  // 100 MHz
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] g);
    checks++;
    if (g !== ex) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Classic cycle; request held until ack is seen at a rising edge, data taken there
  task automatic wb(logic w, logic [4:0] ad, logic [31:0] wd, logic [3:0] s);
    @(posedge clk);
    {cyc, we, adr, dat, sel} <= {1'b1, w, ad, wd, s};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin
      err_total++;
      $display("ERROR ack expected 1 seen %b", ack);
      close_out();
    end
    q = rd;
    cyc <= 0;
  endtask
  initial begin
    {rst, cyc, we, go, adr, dat, sel, gpio} = '0;
    rst = 1;
    void'($urandom(32'h83bf_9c44));
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk("reset_pad", 0, 32'(pad));
    for (a = 0; a < 8; a++) begin
      wb(0, 5'(a * 4), 0, 4'h1);
      chk("reset", 0, q);
    end
    repeat (60) begin
      for (a = 0; a < 5; a++) begin
        wb(1, 5'(a * 4), $urandom, 4'he);
        wb(1, 5'(a * 4), $urandom, 4'h1);
        r[a] = dat[5:0];
      end
      wb(1, 5'h18, $urandom, 4'hf);
      gpio <= 6'($urandom);
      go <= 1;
      @(posedge clk);
      go <= 0;
      repeat (2) @(posedge clk);
      // Model: ownership, then open-drain, drive and pull per pin
      for (n = 0; n < 6; n++) begin
        d = r[0][n];
        o = gpio[n];
        if (spi_en && n > 1) d = sreq[n-2].dir_out;
        if (spi_en && n > 1) o = sreq[n-2].dout;
        if (can_en && n == 1) o = can_tx;
        if (can_en && n < 2) d = (n == 1);
        od = d & r[4][n];
        pe = r[2][n] & (!d | od) & !(can_en && n == 0 && r[3][n]);
        sx[n] = d[0];
        e = {d[0], d[0] & !(od & o), o[0] & !od, d[0] & r[1][n], pe[0], pe[0] & r[3][n]};
        chk("pad", e[4:0] & {1'b1, e[4], 2'b11, e[1]}, pad[n] & {1'b1, e[4], 2'b11, e[1]});
      end
      for (a = 0; a < 7; a++) begin
        wb(0, 5'(a * 4), 0, 4'h1);
        chk("readback", a == 5 ? sx : a == 6 ? 0 : r[a], q);
      end
    end
    close_out();
  end
endmodule
